// ---- rtl/ppde_params.svh ----
// Purpose: Constants for the eight-pin port drive and edge interrupt block.
// Assumes: Byte-wide register port, one register per address.
// Notes:   Definitions only.
`ifndef PPDE_PARAMS_SVH
`define PPDE_PARAMS_SVH
// ============================================================
// Sizes
`define PPDE_NPIN    8
`define PPDE_AW      8
`define PPDE_DW      8
// ============================================================
// Register offsets
`define PPDE_A_OUT   8'h00
`define PPDE_A_PIN   8'h01
`define PPDE_A_DM0   8'h02
`define PPDE_A_DM1   8'h03
`define PPDE_A_DM2   8'h04
`define PPDE_A_BYP   8'h05
`define PPDE_A_BIE   8'h06
`define PPDE_A_REG   8'h07
`define PPDE_A_RISE  8'h08
`define PPDE_A_FALL  8'h09
`define PPDE_A_FLAG  8'h0a
`define PPDE_A_MASK  8'h0b
`define PPDE_A_PINF  5'h02
// ============================================================
// Pin form bit positions
`define PPDE_PF_OUT  3'h0
`define PPDE_PF_DM0  3'h1
`define PPDE_PF_DM1  3'h2
`define PPDE_PF_DM2  3'h3
`define PPDE_PF_BYP  3'h4
`define PPDE_PF_BIE  3'h5
`define PPDE_PF_RISE 3'h6
`define PPDE_PF_FALL 3'h7
// ============================================================
// Values
`define PPDE_ZERO    8'h00
`define PPDE_ONES    8'hff
`define PPDE_RST_OUT 8'h00
`define PPDE_RST_DM  8'h00
`endif

// ---- rtl/ppde_pkg.sv ----
// Purpose: Types shared by the port drive and edge interrupt block.
// Assumes: Drive codes are listed in their numeric order.
// Notes:   None.
package ppde_pkg;
    typedef enum logic [2:0] {
        PPDE_DM_HIZ_ANA,
        PPDE_DM_HIZ_DIG,
        PPDE_DM_RES_UP,
        PPDE_DM_RES_DN,
        PPDE_DM_OD_LO,
        PPDE_DM_OD_HI,
        PPDE_DM_STRONG,
        PPDE_DM_RES_BOTH
    } ppde_dm_t;
endpackage

// ---- rtl/ppde_pin_drive.sv ----
// Purpose: Decode one pin's drive code and output value into enables.
// Assumes: Purely combinational; the caller registers the results.
// Notes:   Regulated mode suppresses every resistive path.
`timescale 1ns/100ps
`default_nettype none
module ppde_pin_drive
    import ppde_pkg::*;
(
    input  wire logic     code_i,
    input  wire logic     val_i,
    input  wire logic     reg_mode_i,
    input  wire ppde_dm_t dm_i,
    output logic          oe_o,
    output logic          pu_o,
    output logic          pd_o
);
    // ============================================================
    // Drive decode
    always_comb begin
        oe_o = 1'b0;
        pu_o = 1'b0;
        pd_o = 1'b0;
        case (dm_i)
            PPDE_DM_HIZ_ANA, PPDE_DM_HIZ_DIG: begin
                oe_o = 1'b0; // RQ2
            end
            PPDE_DM_RES_UP: begin
                pu_o = val_i & ~reg_mode_i; // RQ3 RQ7
                oe_o = ~val_i; // RQ3
            end
            PPDE_DM_RES_DN: begin
                oe_o = val_i; // RQ3
                pd_o = ~val_i & ~reg_mode_i; // RQ3 RQ7
            end
            PPDE_DM_OD_LO: begin
                oe_o = ~val_i; // RQ4
            end
            PPDE_DM_OD_HI: begin
                oe_o = val_i; // RQ5
            end
            PPDE_DM_STRONG: begin
                oe_o = 1'b1; // RQ3
            end
            PPDE_DM_RES_BOTH: begin
                pu_o = val_i & ~reg_mode_i; // RQ3 RQ7
                pd_o = ~val_i & ~reg_mode_i; // RQ3 RQ7
            end
            default: begin
                oe_o = 1'b0;
            end
        endcase
        oe_o = oe_o & code_i;
    end
endmodule
`default_nettype wire

// ---- rtl/ppde_edge_det.sv ----
// Purpose: Synchronise one pin and flag its selected edges.
// Assumes: The pin is asynchronous to the system clock.
// Notes:   Event is a one-cycle pulse from flip-flop state.
`timescale 1ns/100ps
`default_nettype none
module ppde_edge_det (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic pin_i,
    input  wire logic rise_en_i,
    input  wire logic fall_en_i,
    output logic      level_o,
    output logic      event_o
);
    logic sync1_ff;
    logic sync2_ff;
    logic prev_ff;
    // ============================================================
    // Synchroniser and history
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            prev_ff  <= 1'b0;
        end else begin
            sync1_ff <= pin_i;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff; // RQ18
        end
    end
    assign level_o = sync2_ff;
    assign event_o = (rise_en_i & sync2_ff & ~prev_ff)
                   | (fall_en_i & ~sync2_ff & prev_ff); // RQ8 RQ13
    // ============================================================
    // Checks
    AST_EDGE_ONLY: assert property ( // RQ13
        @(posedge clk_i) disable iff (!rst_n_i)
        $stable(sync2_ff) |-> !event_o)
        else $error("Event without an edge.");
    AST_EDGE_RISE: assert property ( // RQ8
        @(posedge clk_i) disable iff (!rst_n_i)
        (rise_en_i && $rose(sync2_ff)) |-> event_o)
        else $error("Rising edge missed.");
endmodule
`default_nettype wire

// ---- rtl/ppde_port.sv ----
// Purpose: Eight-pin port: drive decode, bypass, registers, edge irq.
// Assumes: Pins are asynchronous; fabric signals share SYS_CLK_I.
// Notes:   Reads return data in the cycle after the read strobe.
//
// Summary of operation
// RQ1 - Each pin has its own three-bit drive code.
// RQ2 - Codes 0 and 1 enable no driver and no pull.
// RQ3 - Codes 2, 3, 6, 7 mix resistive and strong drive per table.
// RQ4 - Code 4 drives low strongly, high impedance for one.
// RQ5 - Code 5 drives high strongly, high impedance for zero.
// RQ6 - Output value comes from latch, or fabric when bypass is set.
// RQ7 - Regulated output mode disables every resistive pull path.
// RQ8 - Each pin interrupts on rising, falling, both or no edge.
// RQ9 - All pin events combine into one port interrupt.
// RQ10 - Pin state readback is separate from the output latch.
// RQ11 - Port form and pin form registers share the same storage.
// RQ12 - Reset loads a user-chosen drive and output state.
// RQ13 - Detection is edge only; levels are left to fabric logic.
// RQ14 - Pin input and output control connect to the fabric.
// RQ15 - Processor and DMA use pins through the data registers.
// RQ16 - A configured edge sets the pin's flag and raises interrupt.
// RQ17 - Fabric output enable switches pin between input and drive.
// RQ18 - Synchronised samples are compared; reading flags clears them.
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "ppde_params.svh"
module ppde_port
    import ppde_pkg::*;
#(
    parameter logic [7:0] RST_OUT = `PPDE_RST_OUT,
    parameter logic [7:0] RST_DM0 = `PPDE_RST_DM,
    parameter logic [7:0] RST_DM1 = `PPDE_RST_DM,
    parameter logic [7:0] RST_DM2 = `PPDE_RST_DM
)
(
    input  wire logic       SYS_CLK_I,
    input  wire logic       RST_N_I,
    input  wire logic [7:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    output logic      [7:0] RDATA_O,
    input  wire logic [7:0] PIN_I,
    output logic      [7:0] PIN_OUT_O,
    output logic      [7:0] PIN_OE_O,
    output logic      [7:0] PIN_PULLUP_O,
    output logic      [7:0] PIN_PULLDN_O,
    input  wire logic [7:0] FAB_OUT_I,
    input  wire logic [7:0] FAB_OE_I,
    output logic      [7:0] FAB_IN_O,
    output logic            IRQ_O
);
    // ============================================================
    // Declarations
    logic [7:0] out_latch_ff;
    logic [7:0] dm0_ff;
    logic [7:0] dm1_ff;
    logic [7:0] dm2_ff;
    logic [7:0] byp_ff;
    logic [7:0] bie_ff;
    logic [7:0] reg_mode_ff;
    logic [7:0] rise_ff;
    logic [7:0] fall_ff;
    logic [7:0] flag_ff;
    logic [7:0] mask_ff;
    logic [7:0] rdata_ff;
    logic [7:0] pin_out_ff;
    logic [7:0] pin_oe_ff;
    logic [7:0] pullup_ff;
    logic [7:0] pulldn_ff;
    logic       irq_ff;
    logic [7:0] nxt_out_latch;
    logic [7:0] nxt_dm0;
    logic [7:0] nxt_dm1;
    logic [7:0] nxt_dm2;
    logic [7:0] nxt_byp;
    logic [7:0] nxt_bie;
    logic [7:0] nxt_rise;
    logic [7:0] nxt_fall;
    logic [7:0] nxt_flag;
    logic [7:0] nxt_rdata;
    logic [7:0] flag_clr_w;
    logic [7:0] evt_w;
    logic [7:0] level_w;
    logic [7:0] val_w;
    logic [7:0] drive_en_w;
    logic [7:0] oe_w;
    logic [7:0] pu_w;
    logic [7:0] pd_w;
    logic [7:0] hiz_w;
    logic       pf_wr_w;
    logic       pf_hit_w;
    logic [2:0] pin_idx_w;
    ppde_dm_t   dm_w [`PPDE_NPIN];

    // ============================================================
    // Register port decode
    assign pf_hit_w  = (ADDR_I[7:3] == `PPDE_A_PINF);
    assign pf_wr_w   = WR_I & pf_hit_w;
    assign pin_idx_w = ADDR_I[2:0];

    function automatic logic [7:0] f_upd(
        input logic [7:0] cur,
        input logic       phit,
        input logic [2:0] pos,
        input logic [7:0] wd,
        input logic       pfw,
        input logic [2:0] idx
    );
        logic [7:0] r;
        r = cur;
        if (phit) begin
            r = wd;
        end
        if (pfw) begin
            r[idx] = wd[pos];
        end
        return r;
    endfunction

    assign nxt_out_latch = f_upd(out_latch_ff, WR_I && ADDR_I == `PPDE_A_OUT,
        `PPDE_PF_OUT, WDATA_I, pf_wr_w, pin_idx_w); // RQ11 RQ15
    assign nxt_dm0 = f_upd(dm0_ff, WR_I && ADDR_I == `PPDE_A_DM0,
        `PPDE_PF_DM0, WDATA_I, pf_wr_w, pin_idx_w); // RQ1 RQ11
    assign nxt_dm1 = f_upd(dm1_ff, WR_I && ADDR_I == `PPDE_A_DM1,
        `PPDE_PF_DM1, WDATA_I, pf_wr_w, pin_idx_w); // RQ1 RQ11
    assign nxt_dm2 = f_upd(dm2_ff, WR_I && ADDR_I == `PPDE_A_DM2,
        `PPDE_PF_DM2, WDATA_I, pf_wr_w, pin_idx_w); // RQ1 RQ11
    assign nxt_byp = f_upd(byp_ff, WR_I && ADDR_I == `PPDE_A_BYP,
        `PPDE_PF_BYP, WDATA_I, pf_wr_w, pin_idx_w); // RQ11
    assign nxt_bie = f_upd(bie_ff, WR_I && ADDR_I == `PPDE_A_BIE,
        `PPDE_PF_BIE, WDATA_I, pf_wr_w, pin_idx_w); // RQ11
    assign nxt_rise = f_upd(rise_ff, WR_I && ADDR_I == `PPDE_A_RISE,
        `PPDE_PF_RISE, WDATA_I, pf_wr_w, pin_idx_w); // RQ11
    assign nxt_fall = f_upd(fall_ff, WR_I && ADDR_I == `PPDE_A_FALL,
        `PPDE_PF_FALL, WDATA_I, pf_wr_w, pin_idx_w); // RQ11

    // ============================================================
    // Output and drive configuration storage
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            out_latch_ff <= RST_OUT; // RQ12
            dm0_ff       <= RST_DM0; // RQ12
            dm1_ff       <= RST_DM1; // RQ12
            dm2_ff       <= RST_DM2; // RQ12
        end else begin
            out_latch_ff <= nxt_out_latch;
            dm0_ff       <= nxt_dm0;
            dm1_ff       <= nxt_dm1;
            dm2_ff       <= nxt_dm2;
        end
    end

    // ============================================================
    // Routing and mode storage
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            byp_ff      <= `PPDE_ZERO;
            bie_ff      <= `PPDE_ZERO;
            reg_mode_ff <= `PPDE_ZERO;
        end else begin
            byp_ff <= nxt_byp;
            bie_ff <= nxt_bie;
            if (WR_I && ADDR_I == `PPDE_A_REG) begin
                reg_mode_ff <= WDATA_I;
            end
        end
    end

    // ============================================================
    // Interrupt configuration storage
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            rise_ff <= `PPDE_ZERO;
            fall_ff <= `PPDE_ZERO;
            mask_ff <= `PPDE_ZERO;
        end else begin
            rise_ff <= nxt_rise; // RQ8
            fall_ff <= nxt_fall; // RQ8
            if (WR_I && ADDR_I == `PPDE_A_MASK) begin
                mask_ff <= WDATA_I;
            end
        end
    end

    // ============================================================
    // Per-pin edge detection and drive decode
    for (genvar k = 0; k < `PPDE_NPIN; k++) begin : g_pin
        assign dm_w[k] = ppde_dm_t'({dm2_ff[k], dm1_ff[k], dm0_ff[k]}); // RQ1
        assign val_w[k] = byp_ff[k] ? FAB_OUT_I[k] : out_latch_ff[k]; // RQ6
        assign drive_en_w[k] = ~bie_ff[k] | FAB_OE_I[k]; // RQ17
        assign hiz_w[k] = ~drive_en_w[k]
                        | (dm_w[k] == PPDE_DM_HIZ_ANA)
                        | (dm_w[k] == PPDE_DM_HIZ_DIG);
        ppde_edge_det u_edge (
            .clk_i     (SYS_CLK_I),
            .rst_n_i   (RST_N_I),
            .pin_i     (PIN_I[k]),
            .rise_en_i (rise_ff[k]),
            .fall_en_i (fall_ff[k]),
            .level_o   (level_w[k]),
            .event_o   (evt_w[k])
        );
        ppde_pin_drive u_drive (
            .code_i     (drive_en_w[k]),
            .val_i      (val_w[k]),
            .reg_mode_i (reg_mode_ff[k]),
            .dm_i       (dm_w[k]),
            .oe_o       (oe_w[k]),
            .pu_o       (pu_w[k]),
            .pd_o       (pd_w[k])
        );
    end

    // ============================================================
    // Registered pin controls
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            pin_out_ff <= `PPDE_ZERO;
            pin_oe_ff  <= `PPDE_ZERO;
            pullup_ff  <= `PPDE_ZERO;
            pulldn_ff  <= `PPDE_ZERO;
        end else begin
            pin_out_ff <= val_w; // RQ6
            pin_oe_ff  <= oe_w; // RQ17
            pullup_ff  <= pu_w & drive_en_w; // RQ7 RQ17
            pulldn_ff  <= pd_w & drive_en_w; // RQ7 RQ17
        end
    end
    assign PIN_OUT_O    = pin_out_ff;
    assign PIN_OE_O     = pin_oe_ff;
    assign PIN_PULLUP_O = pullup_ff;
    assign PIN_PULLDN_O = pulldn_ff;
    assign FAB_IN_O     = level_w; // RQ14

    // ============================================================
    // Event flags and interrupt
    always_comb begin
        flag_clr_w = `PPDE_ZERO;
        if (RD_I && ADDR_I == `PPDE_A_FLAG) begin
            flag_clr_w = `PPDE_ONES; // RQ18
        end else if (WR_I && ADDR_I == `PPDE_A_FLAG) begin
            flag_clr_w = WDATA_I;
        end
    end
    assign nxt_flag = (flag_ff & ~flag_clr_w) | evt_w; // RQ16

    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            flag_ff <= `PPDE_ZERO;
            irq_ff  <= 1'b0;
        end else begin
            flag_ff <= nxt_flag; // RQ16
            irq_ff  <= |(flag_ff & mask_ff); // RQ9
        end
    end
    assign IRQ_O = irq_ff;

    // ============================================================
    // Read data
    always_comb begin
        nxt_rdata = `PPDE_ZERO;
        case (ADDR_I)
            `PPDE_A_OUT:  nxt_rdata = out_latch_ff;
            `PPDE_A_PIN:  nxt_rdata = level_w; // RQ10
            `PPDE_A_DM0:  nxt_rdata = dm0_ff;
            `PPDE_A_DM1:  nxt_rdata = dm1_ff;
            `PPDE_A_DM2:  nxt_rdata = dm2_ff;
            `PPDE_A_BYP:  nxt_rdata = byp_ff;
            `PPDE_A_BIE:  nxt_rdata = bie_ff;
            `PPDE_A_REG:  nxt_rdata = reg_mode_ff;
            `PPDE_A_RISE: nxt_rdata = rise_ff;
            `PPDE_A_FALL: nxt_rdata = fall_ff;
            `PPDE_A_FLAG: nxt_rdata = flag_ff;
            `PPDE_A_MASK: nxt_rdata = mask_ff;
            default: begin
                if (pf_hit_w) begin
                    nxt_rdata = {fall_ff[pin_idx_w], rise_ff[pin_idx_w],
                                 bie_ff[pin_idx_w], byp_ff[pin_idx_w],
                                 dm2_ff[pin_idx_w], dm1_ff[pin_idx_w],
                                 dm0_ff[pin_idx_w],
                                 out_latch_ff[pin_idx_w]}; // RQ11
                end
            end
        endcase
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            rdata_ff <= `PPDE_ZERO;
        end else if (RD_I) begin
            rdata_ff <= nxt_rdata; // RQ15
        end else begin
            rdata_ff <= `PPDE_ZERO;
        end
    end
    assign RDATA_O = rdata_ff;

    // ============================================================
    // Checks
    AST_HIZ_CODES: assert property ( // RQ2
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        ##1 ((PIN_OE_O | PIN_PULLUP_O | PIN_PULLDN_O) & $past(hiz_w))
            == 8'h00)
        else $error("Driver enabled in a high impedance mode.");
    AST_OD_LOW: assert property ( // RQ4
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (dm_w[0] == PPDE_DM_OD_LO && drive_en_w[0] && !val_w[0])
        |=> (PIN_OE_O[0] && !PIN_OUT_O[0]))
        else $error("Open drain low not driving low.");
    AST_OD_HIGH: assert property ( // RQ5
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (dm_w[0] == PPDE_DM_OD_HI && !val_w[0])
        |=> !PIN_OE_O[0] && !PIN_PULLUP_O[0] && !PIN_PULLDN_O[0])
        else $error("Open drain high drives a zero.");
    AST_RES_BOTH: assert property ( // RQ3
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (dm_w[0] == PPDE_DM_RES_BOTH && drive_en_w[0] && !reg_mode_ff[0])
        |=> (PIN_PULLUP_O[0] == PIN_OUT_O[0]) && !PIN_OE_O[0])
        else $error("Resistive both ways misdecoded.");
    AST_REG_MODE: assert property ( // RQ7
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        reg_mode_ff[0] |=> !PIN_PULLUP_O[0] && !PIN_PULLDN_O[0])
        else $error("Pull enabled in regulated mode.");
    AST_BYPASS: assert property ( // RQ6
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        byp_ff[0] |=> PIN_OUT_O[0] == $past(FAB_OUT_I[0]))
        else $error("Bypass did not route the fabric value.");
    AST_BIDIR: assert property ( // RQ17
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (bie_ff[1] && !FAB_OE_I[1])
        |=> !PIN_OE_O[1] && !PIN_PULLUP_O[1] && !PIN_PULLDN_O[1])
        else $error("Bidirectional pin drove while disabled.");
    AST_FLAG_SET: assert property ( // RQ16
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (|evt_w) |=> (flag_ff & $past(evt_w)) == $past(evt_w))
        else $error("Edge event lost.");
    AST_IRQ: assert property ( // RQ9
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (evt_w[2] && mask_ff[2]) ##1 mask_ff[2] |=> IRQ_O)
        else $error("Port interrupt not raised.");
    AST_RD_CLR: assert property ( // RQ18
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (RD_I && ADDR_I == `PPDE_A_FLAG && evt_w == 8'h00)
        |=> flag_ff == 8'h00 && RDATA_O == $past(flag_ff))
        else $error("Flag read did not return and clear.");
    AST_PIN_READ: assert property ( // RQ10
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (RD_I && ADDR_I == `PPDE_A_PIN) |=> RDATA_O == $past(level_w))
        else $error("Pin state readback wrong.");
    AST_PIN_FORM: assert property ( // RQ11
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (WR_I && ADDR_I == 8'h13)
        |=> dm2_ff[3] == $past(WDATA_I[3]) && byp_ff[3] == $past(WDATA_I[4]))
        else $error("Pin form write missed port storage.");
endmodule
`default_nettype wire

// ---- tb/ppde_board.sv ----
// Purpose: Board model that resolves the eight port pin levels.
// Assumes: Bench-driven external sources act on pins whose strong driver is off, and override any pull.
// Notes:   A pin that nothing holds flips to the inverse of its last level.
`timescale 1ns/100ps
`default_nettype none
module ppde_board (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [7:0] out_i,
    input  wire logic [7:0] oe_i,
    input  wire logic [7:0] pu_i,
    input  wire logic [7:0] pd_i,
    input  wire logic [7:0] ext_en_i,
    input  wire logic [7:0] ext_val_i,
    output logic      [7:0] pin_o
);
    logic [7:0] float_ff;
    // Floating pins must not settle to a stable guess.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            float_ff <= 8'h00;
        end else begin
            float_ff <= ~pin_o;
        end
    end
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            if (oe_i[k])
                pin_o[k] = out_i[k];
            else if (ext_en_i[k])
                pin_o[k] = ext_val_i[k];
            else if (pu_i[k])
                pin_o[k] = 1'b1;
            else if (pd_i[k])
                pin_o[k] = 1'b0;
            else
                pin_o[k] = float_ff[k];
        end
    end
endmodule
`default_nettype wire

// ---- tb/ppde_port_tb.sv ----
// Purpose: Self-checking bench for the port drive and edge interrupt block.
// Assumes: Register reads return data in the cycle after the strobe.
// Notes:   Pins are resolved by the board model.
`timescale 1ns/100ps
`default_nettype none
`include "ppde_params.svh"
module ppde_port_tb;
    logic       clk, rst_n, wr_s, rd_s, irq;
    logic [7:0] addr, wdata, rdata, pin, pin_out, pin_oe, pu, pd;
    logic [7:0] fab_out, fab_oe, fab_in, ext_en, ext_val;
    logic [7:0] dm0, dm1, dm2, e_oe, e_pu, e_pd, val;
    logic [2:0] code, eb;
    int         err_count, num_checks;
    ppde_port dut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata),
        .PIN_I(pin), .PIN_OUT_O(pin_out), .PIN_OE_O(pin_oe),
        .PIN_PULLUP_O(pu), .PIN_PULLDN_O(pd), .FAB_OUT_I(fab_out),
        .FAB_OE_I(fab_oe), .FAB_IN_O(fab_in), .IRQ_O(irq));
    ppde_board board (.clk_i(clk), .rst_n_i(rst_n), .out_i(pin_out),
        .oe_i(pin_oe),
        .pu_i(pu), .pd_i(pd), .ext_en_i(ext_en), .ext_val_i(ext_val),
        .pin_o(pin));
    // ============================================================
    // Clock, tasks
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic check(input string n, input logic [7:0] s,
                         input logic [7:0] e);
        num_checks++;
        if (s !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        check("read data", rdata, e);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic set_dm(input logic [7:0] a, input logic [7:0] b,
                          input logic [7:0] c);
        wr(`PPDE_A_DM0, a);
        wr(`PPDE_A_DM1, b);
        wr(`PPDE_A_DM2, c);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Returns strong, pull-up, pull-down enables for one pin.
    function automatic logic [2:0] drv(input logic [2:0] c, input logic v);
        case (c)
            3'h2: drv = v ? 3'b010 : 3'b100;
            3'h3: drv = v ? 3'b100 : 3'b001;
            3'h4: drv = v ? 3'b000 : 3'b100;
            3'h5: drv = v ? 3'b100 : 3'b000;
            3'h6: drv = 3'b100;
            3'h7: drv = v ? 3'b010 : 3'b001;
            default: drv = 3'b000;
        endcase
    endfunction
    initial begin
        #1000000;
        err_count++;
        close_out();
    end
    // ============================================================
    // Tests
    initial begin
        err_count = 0;
        num_checks = 0;
        rst_n = 1'b0;
        {wr_s, rd_s} = 2'b00;
        {addr, wdata, fab_out, fab_oe, ext_en, ext_val} = '0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        settle(2);
        check("irq", {7'h00, irq}, 8'h00);
        check("oe", pin_oe | pu | pd, 8'h00);
        rd(`PPDE_A_DM2, `PPDE_RST_DM);
        rd(`PPDE_A_OUT, `PPDE_RST_OUT);
        $display("test reset done");
        for (int c = 0; c < 8; c++) begin
            for (int v = 0; v < 2; v++) begin
                val = v ? 8'h5a : 8'ha5;
                for (int k = 0; k < 8; k++) begin
                    code = 3'((c + k) % 8);
                    {dm2[k], dm1[k], dm0[k]} = code;
                    eb = drv(code, val[k]);
                    {e_oe[k], e_pu[k], e_pd[k]} = eb;
                end
                wr(`PPDE_A_OUT, val);
                set_dm(dm0, dm1, dm2);
                settle(3);
                check("pin out", pin_out, val);
                check("oe", pin_oe, e_oe);
                check("pullup", pu, e_pu);
                check("pulldn", pd, e_pd);
            end
        end
        $display("test drive table done");
        set_dm(8'hff, 8'hff, 8'hff);
        wr(`PPDE_A_REG, 8'hff);
        settle(3);
        check("pulls", pu | pd, 8'h00);
        wr(`PPDE_A_REG, 8'h00);
        set_dm(8'h00, 8'hff, 8'hff);
        fab_out <= 8'ha5;
        wr(`PPDE_A_BYP, 8'hff);
        settle(3);
        check("pin out", pin_out, 8'ha5);
        fab_oe <= 8'ha5;
        wr(`PPDE_A_BIE, 8'hff);
        settle(3);
        check("oe", pin_oe, 8'ha5);
        wr(`PPDE_A_BIE, 8'h00);
        wr(`PPDE_A_BYP, 8'h00);
        $display("test regulated bypass bidir done");
        wr(8'h12, 8'h0b);
        rd(8'h12, 8'h0b);
        rd(`PPDE_A_DM0, 8'h04);
        rd(`PPDE_A_DM1, 8'hfb);
        rd(`PPDE_A_OUT, 8'h5e);
        $display("test pin form done");
        set_dm(8'hff, 8'h00, 8'h00);
        ext_en <= 8'hff;
        ext_val <= 8'h3c;
        settle(4);
        rd(`PPDE_A_PIN, 8'h3c);
        check("fabric in", fab_in, 8'h3c);
        wr(`PPDE_A_PIN, 8'h00);
        rd(`PPDE_A_PIN, 8'h3c);
        rd(`PPDE_A_OUT, 8'h5e);
        rd(8'h20, 8'h00);
        $display("test readback done");
        ext_val <= 8'h00;
        settle(4);
        wr(`PPDE_A_FLAG, 8'hff);
        wr(`PPDE_A_RISE, 8'h05);
        wr(`PPDE_A_FALL, 8'h06);
        wr(`PPDE_A_MASK, 8'hff);
        ext_val <= 8'hff;
        settle(6);
        check("irq", {7'h00, irq}, 8'h01);
        rd(`PPDE_A_FLAG, 8'h05);
        settle(3);
        check("irq", {7'h00, irq}, 8'h00);
        wr(`PPDE_A_MASK, 8'h00);
        ext_val <= 8'h00;
        settle(6);
        check("irq", {7'h00, irq}, 8'h00);
        wr(`PPDE_A_MASK, 8'hff);
        settle(3);
        check("irq", {7'h00, irq}, 8'h01);
        wr(`PPDE_A_FLAG, 8'h02);
        rd(`PPDE_A_FLAG, 8'h04);
        settle(8);
        rd(`PPDE_A_FLAG, 8'h00);
        $display("test edge interrupt done");
        close_out();
    end
endmodule
`default_nettype wire
